// ### rtl/xsr_pkg.sv
package xsr_pkg;
    // Register offsets on the microprocessor port.
    localparam logic [9:0] OFS_DATA      = 10'h283;
    localparam logic [9:0] OFS_ADDR_HIGH = 10'h28F;
    localparam logic [9:0] OFS_ADDR_MID  = 10'h290;
    localparam logic [9:0] OFS_ADDR_LOW  = 10'h291;
    localparam logic [9:0] OFS_CONFIG    = 10'h292;
    localparam logic [9:0] OFS_XFER_CTRL = 10'h280;
    // Reset values.
    localparam logic [7:0] RST_CONFIG    = 8'h08;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_XFER_CTRL = 8'h80;
    // Field positions.
    localparam int CFG_RX_RST_BIT  = 7;
    localparam int CFG_TX_RST_BIT  = 6;
    localparam int XC_DONE_BIT     = 7;
    localparam int XC_TOGGLE_BIT   = 6;
    localparam int XC_DIR_BIT      = 5;
    localparam logic [1:0] XC_OP_ACCESS = 2'h1;
    localparam logic [3:0] ADDR_HIGH_MASK = 4'hF;
    // Size encodings of the receive memory.
    localparam logic [2:0] SZ_1X32K  = 3'h0;
    localparam logic [2:0] SZ_2X32K  = 3'h1;
    localparam logic [2:0] SZ_1X128K = 3'h2;
    localparam logic [2:0] SZ_2X128K = 3'h3;
    localparam logic [2:0] SZ_1X512K = 3'h4;
    localparam logic [2:0] SZ_2X512K = 3'h5;
    // SRAM access timing.
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int SRAM_ACCESS_PS = 15000;
    localparam int SRAM_ACC_CYC   = (SRAM_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    typedef enum logic [3:0] {
        XS_IDLE  = 4'h1,
        XS_SETUP = 4'h2,
        XS_HOLD  = 4'h4,
        XS_DONE  = 4'h8
    } xsr_state_t;
endpackage : xsr_pkg

// ### rtl/xsr_sram_seq.sv
`timescale 1ns/1ps
`default_nettype none
module xsr_sram_seq
    import xsr_pkg::*;
#(
    parameter int ACC_CYC = SRAM_ACC_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        start,
    input  wire logic        rd_not_wr,
    input  wire logic [19:0] addr,
    input  wire logic [7:0]  wdata,
    output logic             done,
    output logic             rdata_vld,
    output logic [7:0]       rdata,
    output logic [19:0]      sram_addr,
    output logic [7:0]       sram_dq_o,
    output logic             sram_dq_oe,
    input  wire logic [7:0]  sram_dq_i,
    output logic             sram_ce_n,
    output logic             sram_oe_n,
    output logic             sram_we_n
);
    xsr_state_t      state_ff;
    logic [7:0]      cnt_ff;
    logic            rd_ff;

    // Sequencer; the access time is held by counting cycles, no handshake exists on an async SRAM.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_ff <= XS_IDLE;
            cnt_ff   <= 8'h00;
            rd_ff    <= 1'b0;
        end else begin
            case (state_ff)
                XS_IDLE: begin
                    if (start) begin
                        state_ff <= XS_SETUP;
                        rd_ff    <= rd_not_wr;
                    end
                end
                XS_SETUP: begin
                    state_ff <= XS_HOLD;
                    cnt_ff   <= 8'(ACC_CYC);
                end
                XS_HOLD: begin
                    if (cnt_ff <= 8'h01) begin
                        state_ff <= XS_DONE;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                XS_DONE: state_ff <= XS_IDLE;
                default: state_ff <= XS_IDLE;
            endcase
        end
    end

    // Address and write data are captured at start so the pins stay steady through the access.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sram_addr <= 20'h00000;
            sram_dq_o <= 8'h00;
        end else if (state_ff == XS_IDLE && start) begin
            sram_addr <= addr;
            sram_dq_o <= wdata;
        end
    end

    // Strobes come from flip-flops; write enable falls with select and rises one cycle before it, giving hold margin.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sram_ce_n  <= 1'b1;
            sram_oe_n  <= 1'b1;
            sram_we_n  <= 1'b1;
            sram_dq_oe <= 1'b0;
        end else begin
            sram_ce_n  <= !(state_ff == XS_SETUP || state_ff == XS_HOLD);
            sram_oe_n  <= !(rd_ff && (state_ff == XS_SETUP || state_ff == XS_HOLD));
            sram_we_n  <= !(!rd_ff && state_ff == XS_SETUP) && !(!rd_ff && state_ff == XS_HOLD && cnt_ff > 8'h01);
            sram_dq_oe <= !rd_ff && (state_ff == XS_SETUP || state_ff == XS_HOLD);
        end
    end

    // Read data is sampled at the end of the access, while output enable is still low.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata     <= 8'h00;
            rdata_vld <= 1'b0;
        end else begin
            rdata_vld <= 1'b0;
            if (state_ff == XS_HOLD && cnt_ff <= 8'h01 && rd_ff) begin
                rdata     <= sram_dq_i;
                rdata_vld <= 1'b1;
            end
        end
    end

    assign done = (state_ff == XS_DONE);
endmodule : xsr_sram_seq
`default_nettype wire

// ### rtl/xsr_regs.sv
// Function
// RULE1 - Writing 1 to config bit 7 resets the receive path; 0 does nothing.
// RULE2 - Writing 1 to config bit 6 resets the transmit path; 0 does nothing.
// RULE3 - Config bits 2:0 select receive memory banks and bank size.
// RULE4 - Software writes zero to config bits 5:3 in normal use.
// RULE5 - Config register is eight bits, read/write, resets to 08 hex.
// RULE6 - Data register holds the byte to write or the byte read back.
// RULE7 - Low address register holds address bits 7:0, reset zero.
// RULE8 - Mid address register holds address bits 15:8, reset zero.
// RULE9 - High register holds bits 19:16; bits 7:5 read zero, bit 4 reserved.
// RULE10 - Software loads address and data before launching the transfer.
// RULE11 - Control bits 1:0 equal 01 start one access; bit 5 picks direction.
// RULE12 - Any control write clears done bit 7; it sets again when finished. A control write in the cycle a transfer finishes leaves it set.
// RULE13 - The three address registers form one 20-bit address driven to memory.
`timescale 1ns/1ps
`default_nettype none
module xsr_regs
    import xsr_pkg::*;
#(
    parameter int ACC_CYC = SRAM_ACC_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic [9:0]  up_addr,
    input  wire logic [7:0]  up_wdata,
    input  wire logic        up_wr,
    input  wire logic        up_rd,
    output logic [7:0]       up_rdata,
    output logic             rx_path_rst,
    output logic             tx_path_rst,
    output logic [2:0]       mem_size_sel,
    output logic [1:0]       mem_bank_cnt,
    output logic [19:0]      mem_words_per_bank,
    output logic [19:0]      sram_addr,
    output logic [7:0]       sram_dq_o,
    output logic             sram_dq_oe,
    input  wire logic [7:0]  sram_dq_i,
    output logic             sram_ce_n,
    output logic             sram_oe_n,
    output logic             sram_we_n
);
    logic [7:0]  cfg_ff;
    logic [7:0]  data_ff;
    logic [7:0]  addr_low_ff;
    logic [7:0]  addr_mid_ff;
    logic [4:0]  addr_high_ff;
    logic [5:0]  xctl_ff;
    logic        done_ff;
    logic        toggle_ff;
    logic        rx_rst_ff;
    logic        tx_rst_ff;
    logic        start;
    logic        seq_done;
    logic        seq_rvld;
    logic [7:0]  seq_rdata;
    logic [7:0]  nxt_rdata;

    // Decode a write strobe to one register offset.
    function automatic logic wr_hit(input logic [9:0] a, input logic w, input logic [9:0] ofs);
        wr_hit = w && (a == ofs);
    endfunction : wr_hit

    // Configuration register; the two reset bits are write-one pulses and never store.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_ff <= RST_CONFIG; // [RULE5]
        end else if (wr_hit(up_addr, up_wr, OFS_CONFIG)) begin
            cfg_ff <= {2'b00, up_wdata[5:0]}; // [RULE5] [RULE4]
        end
    end

    // Path reset pulses last one cycle after a write of 1; a write of 0 leaves them low.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_rst_ff <= 1'b0;
            tx_rst_ff <= 1'b0;
        end else begin
            rx_rst_ff <= wr_hit(up_addr, up_wr, OFS_CONFIG) && up_wdata[CFG_RX_RST_BIT]; // [RULE1]
            tx_rst_ff <= wr_hit(up_addr, up_wr, OFS_CONFIG) && up_wdata[CFG_TX_RST_BIT]; // [RULE2]
        end
    end

    assign rx_path_rst  = rx_rst_ff;
    assign tx_path_rst  = tx_rst_ff;
    assign mem_size_sel = cfg_ff[2:0];

    // Memory geometry decoded from the size field; reserved codes fall back to the smallest.
    always_comb begin
        mem_bank_cnt       = 2'h1;
        mem_words_per_bank = 20'h08000;
        case (cfg_ff[2:0]) // [RULE3]
            SZ_1X32K:  begin mem_bank_cnt = 2'h1; mem_words_per_bank = 20'h08000; end
            SZ_2X32K:  begin mem_bank_cnt = 2'h2; mem_words_per_bank = 20'h08000; end
            SZ_1X128K: begin mem_bank_cnt = 2'h1; mem_words_per_bank = 20'h20000; end
            SZ_2X128K: begin mem_bank_cnt = 2'h2; mem_words_per_bank = 20'h20000; end
            SZ_1X512K: begin mem_bank_cnt = 2'h1; mem_words_per_bank = 20'h80000; end
            SZ_2X512K: begin mem_bank_cnt = 2'h2; mem_words_per_bank = 20'h80000; end
            default:   begin mem_bank_cnt = 2'h1; mem_words_per_bank = 20'h08000; end
        endcase
    end

    // Data register takes a software write, and a finished read overwrites it.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            data_ff <= RST_ZERO; // [RULE6]
        end else if (seq_rvld) begin
            data_ff <= seq_rdata; // [RULE6] [RULE11]
        end else if (wr_hit(up_addr, up_wr, OFS_DATA)) begin
            data_ff <= up_wdata; // [RULE6]
        end
    end

    // Address byte registers.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            addr_low_ff  <= RST_ZERO; // [RULE7]
            addr_mid_ff  <= RST_ZERO; // [RULE8]
            addr_high_ff <= 5'h00; // [RULE9]
        end else begin
            if (wr_hit(up_addr, up_wr, OFS_ADDR_LOW)) begin
                addr_low_ff <= up_wdata; // [RULE7]
            end
            if (wr_hit(up_addr, up_wr, OFS_ADDR_MID)) begin
                addr_mid_ff <= up_wdata; // [RULE8]
            end
            if (wr_hit(up_addr, up_wr, OFS_ADDR_HIGH)) begin
                addr_high_ff <= up_wdata[4:0]; // [RULE9]
            end
        end
    end

    // Transfer control: writable bits 5:0 stored; a write with 01 in bits 1:0 launches an access.
    assign start = wr_hit(up_addr, up_wr, OFS_XFER_CTRL) && (up_wdata[1:0] == XC_OP_ACCESS); // [RULE11]

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            xctl_ff <= 6'h00;
        end else if (wr_hit(up_addr, up_wr, OFS_XFER_CTRL)) begin
            xctl_ff <= up_wdata[5:0];
        end
    end

    // Done bit: any control write clears it; after a write that launches nothing it sets again on the next cycle.
    // A sequencer finish in the same cycle wins over the clear, and can coincide with a control write made while busy.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            done_ff   <= RST_XFER_CTRL[XC_DONE_BIT];
            toggle_ff <= 1'b0;
        end else begin
            if (seq_done) begin
                done_ff   <= 1'b1; // [RULE12]
                toggle_ff <= ~toggle_ff;
            end else if (wr_hit(up_addr, up_wr, OFS_XFER_CTRL)) begin
                done_ff <= 1'b0; // [RULE12]
            end else if (!done_ff && xctl_ff[1:0] != XC_OP_ACCESS) begin
                done_ff <= 1'b1; // [RULE12]
            end
        end
    end

    // Sequencer drives the assembled 20-bit address to the memory unchanged.
    xsr_sram_seq #(
        .ACC_CYC    (ACC_CYC)
    ) u_seq (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .start      (start),
        .rd_not_wr  (up_wdata[XC_DIR_BIT]),
        .addr       ({addr_high_ff[3:0] & ADDR_HIGH_MASK, addr_mid_ff, addr_low_ff}), // [RULE13] [RULE10]
        .wdata      (data_ff),
        .done       (seq_done),
        .rdata_vld  (seq_rvld),
        .rdata      (seq_rdata),
        .sram_addr  (sram_addr),
        .sram_dq_o  (sram_dq_o),
        .sram_dq_oe (sram_dq_oe),
        .sram_dq_i  (sram_dq_i),
        .sram_ce_n  (sram_ce_n),
        .sram_oe_n  (sram_oe_n),
        .sram_we_n  (sram_we_n)
    );

    // Read mux; unmapped offsets read as zero, bits 7:5 of the high address always zero.
    always_comb begin
        case (up_addr)
            OFS_CONFIG:    nxt_rdata = cfg_ff;
            OFS_DATA:      nxt_rdata = data_ff;
            OFS_ADDR_LOW:  nxt_rdata = addr_low_ff;
            OFS_ADDR_MID:  nxt_rdata = addr_mid_ff;
            OFS_ADDR_HIGH: nxt_rdata = {3'b000, addr_high_ff}; // [RULE9]
            OFS_XFER_CTRL: nxt_rdata = {done_ff, toggle_ff, xctl_ff};
            default:       nxt_rdata = 8'h00;
        endcase
    end

    // Read data is registered so the port sees a clean flop output one cycle after the strobe.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            up_rdata <= 8'h00;
        end else if (up_rd) begin
            up_rdata <= nxt_rdata;
        end
    end
endmodule : xsr_regs
`default_nettype wire

// ### verification/xsr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Ties the register port and the SRAM strobes of the access block to their causes.
module xsr_regs_monitor
    import xsr_pkg::*;
#(
    parameter int ACC_CYC = SRAM_ACC_CYC
) (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic [9:0]  up_addr,
    input wire logic [7:0]  up_wdata,
    input wire logic        up_wr,
    input wire logic        up_rd,
    input wire logic [7:0]  up_rdata,
    input wire logic        rx_path_rst,
    input wire logic        tx_path_rst,
    input wire logic [2:0]  mem_size_sel,
    input wire logic [1:0]  mem_bank_cnt,
    input wire logic [19:0] sram_addr,
    input wire logic [7:0]  sram_dq_o,
    input wire logic        sram_dq_oe,
    input wire logic        sram_ce_n,
    input wire logic        sram_oe_n,
    input wire logic        sram_we_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire logic cw = up_wr && up_addr == OFS_CONFIG;
    wire logic xw = up_wr && up_addr == OFS_XFER_CTRL;
    logic [19:0] adr_ff;
    logic [7:0]  dat_ff;
    // Shadow of what software loaded, so the pins can be checked against it.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            adr_ff <= 20'h00000;
            dat_ff <= 8'h00;
        end else if (up_wr) begin
            if (up_addr == OFS_ADDR_HIGH) adr_ff[19:16] <= up_wdata[3:0];
            if (up_addr == OFS_ADDR_MID) adr_ff[15:8] <= up_wdata;
            if (up_addr == OFS_ADDR_LOW) adr_ff[7:0] <= up_wdata;
            if (up_addr == OFS_DATA) dat_ff <= up_wdata;
        end
    end
    sequence s_wr_go;
        xw && up_wdata[1:0] == XC_OP_ACCESS && !up_wdata[XC_DIR_BIT];
    endsequence
    sequence s_rd_go;
        xw && up_wdata[1:0] == XC_OP_ACCESS && up_wdata[XC_DIR_BIT];
    endsequence
    // Address is part of each strobe step, so it is checked while the access is on the pins.
    sequence s_wr_strb;
        !sram_ce_n && !sram_we_n && sram_oe_n && sram_dq_oe && sram_dq_o == dat_ff && sram_addr == adr_ff;
    endsequence
    sequence s_rd_strb;
        !sram_ce_n && !sram_oe_n && sram_we_n && !sram_dq_oe && sram_addr == adr_ff;
    endsequence
    a_rst_pulse: assert property (cw |=>
        rx_path_rst == $past(up_wdata[7]) && tx_path_rst == $past(up_wdata[6]))
        else $error("path reset pulse wrong after config write");
    a_rst_cause: assert property (rx_path_rst || tx_path_rst |-> $past(cw))
        else $error("path reset without config write");
    a_size_load: assert property (cw |=> mem_size_sel == $past(up_wdata[2:0]))
        else $error("memory size not loaded");
    a_bank_count: assert property (mem_size_sel inside {[3'h0:3'h5]} |->
        mem_bank_cnt == (mem_size_sel[0] ? 2'h2 : 2'h1))
        else $error("bank count wrong for size code");
    a_high_zero: assert property (up_rd && up_addr == OFS_ADDR_HIGH |=> up_rdata[7:5] == 3'h0)
        else $error("top address bits 7:5 not zero");
    a_rdata_hold: assert property (!up_rd |=> $stable(up_rdata))
        else $error("read data changed without a read");
    a_wr_access: assert property (s_wr_go |-> ##2 s_wr_strb)
        else $error("write access strobes, data or address wrong");
    a_rd_access: assert property (s_rd_go |-> ##2 s_rd_strb)
        else $error("read access strobes or address wrong");
    a_no_access: assert property (xw && up_wdata[1:0] != XC_OP_ACCESS |=> sram_ce_n [*4])
        else $error("memory selected without an access code");
endmodule : xsr_regs_monitor
bind xsr_regs xsr_regs_monitor #(.ACC_CYC(ACC_CYC)) u_mon (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .up_addr      (up_addr),
    .up_wdata     (up_wdata),
    .up_wr        (up_wr),
    .up_rd        (up_rd),
    .up_rdata     (up_rdata),
    .rx_path_rst  (rx_path_rst),
    .tx_path_rst  (tx_path_rst),
    .mem_size_sel (mem_size_sel),
    .mem_bank_cnt (mem_bank_cnt),
    .sram_addr    (sram_addr),
    .sram_dq_o    (sram_dq_o),
    .sram_dq_oe   (sram_dq_oe),
    .sram_ce_n    (sram_ce_n),
    .sram_oe_n    (sram_oe_n),
    .sram_we_n    (sram_we_n)
);
`default_nettype wire

// ### verification/xsr_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Byte-wide asynchronous SRAM that answers within the same cycle.
module xsr_sram_model (
    input  wire logic        clk_sys,
    input  wire logic [19:0] sram_addr,
    input  wire logic [7:0]  sram_dq_o,
    input  wire logic        sram_dq_oe,
    input  wire logic        sram_ce_n,
    input  wire logic        sram_oe_n,
    input  wire logic        sram_we_n,
    output logic      [7:0]  sram_dq_i
);
    logic [7:0] mem [0:1048575];
    logic [7:0] last_ff = 8'h00;
    // A byte lands only while select, write enable and the driver are all on.
    always @(posedge clk_sys) begin
        if (!sram_ce_n && !sram_we_n && sram_dq_oe) begin
            mem[sram_addr] <= sram_dq_o;
        end
        if (!sram_ce_n && !sram_oe_n) begin
            last_ff <= sram_dq_i;
        end
    end
    // Undriven lines show the inverse of the last byte, so a stale sample is caught.
    always_comb begin
        if (!sram_ce_n && !sram_oe_n && sram_we_n) sram_dq_i = mem[sram_addr];
        else sram_dq_i = ~last_ff;
    end
endmodule : xsr_sram_model
`default_nettype wire

// ### verification/tb_ext_rx_sram_access_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb_ext_rx_sram_access_regs
    import xsr_pkg::*;
;
    logic        clk_sys = 1'b0, srst = 1'b1, up_wr = 1'b0, up_rd = 1'b0;
    logic [9:0]  up_addr = 10'h000;
    logic [7:0]  up_wdata = 8'h00, up_rdata, rv, sram_dq_o, sram_dq_i;
    logic        rx_path_rst, tx_path_rst, sram_dq_oe, sram_ce_n, sram_oe_n, sram_we_n;
    logic [2:0]  mem_size_sel;
    logic [1:0]  mem_bank_cnt;
    logic [19:0] mem_words_per_bank, sram_addr;
    int          n_mismatch = 0, num_checks = 0;
    logic [9:0]  ra [7] = '{OFS_CONFIG, OFS_DATA, OFS_ADDR_LOW, OFS_ADDR_MID, OFS_ADDR_HIGH, OFS_XFER_CTRL, 10'h284};
    logic [7:0]  re [7] = '{RST_CONFIG, 8'h00, 8'h00, 8'h00, 8'h00, RST_XFER_CTRL, 8'h00};
    // A short access count keeps polling brief but leaves two cycles of busy margin.
    xsr_regs #(.ACC_CYC(2)) dut (
        .clk_sys            (clk_sys),
        .srst               (srst),
        .up_addr            (up_addr),
        .up_wdata           (up_wdata),
        .up_wr              (up_wr),
        .up_rd              (up_rd),
        .up_rdata           (up_rdata),
        .rx_path_rst        (rx_path_rst),
        .tx_path_rst        (tx_path_rst),
        .mem_size_sel       (mem_size_sel),
        .mem_bank_cnt       (mem_bank_cnt),
        .mem_words_per_bank (mem_words_per_bank),
        .sram_addr          (sram_addr),
        .sram_dq_o          (sram_dq_o),
        .sram_dq_oe         (sram_dq_oe),
        .sram_dq_i          (sram_dq_i),
        .sram_ce_n          (sram_ce_n),
        .sram_oe_n          (sram_oe_n),
        .sram_we_n          (sram_we_n)
    );
    xsr_sram_model sram (
        .clk_sys    (clk_sys),
        .sram_addr  (sram_addr),
        .sram_dq_o  (sram_dq_o),
        .sram_dq_oe (sram_dq_oe),
        .sram_ce_n  (sram_ce_n),
        .sram_oe_n  (sram_oe_n),
        .sram_we_n  (sram_we_n),
        .sram_dq_i  (sram_dq_i)
    );
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        up_wr = 1'b1;
        up_addr = a;
        up_wdata = d;
        @(posedge clk_sys) #1;
        up_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a);
        @(posedge clk_sys) #1;
        up_rd = 1'b1;
        up_addr = a;
        @(posedge clk_sys) #1;
        up_rd = 1'b0;
        rv = up_rdata;
    endtask : rd
    // Software polls the done bit; the poll count bounds a hung transfer.
    task automatic poll;
        for (int i = 0; i < 20; i++) begin
            rd(OFS_XFER_CTRL);
            if (rv[7] === 1'b1) break;
        end
        `CHK(rv[7], 1'b1)
    endtask : poll
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        #1 srst = 1'b0;
        foreach (ra[i]) begin
            rd(ra[i]);
            `CHK(rv, re[i])
        end
        $display("test reset values done");
        wr(OFS_CONFIG, 8'hC5);
        `CHK({rx_path_rst, tx_path_rst}, 2'h3)
        rd(OFS_CONFIG);
        `CHK(rv, 8'h05)
        wr(OFS_CONFIG, 8'h40);
        `CHK({rx_path_rst, tx_path_rst}, 2'h1)
        for (int s = 0; s < 6; s++) begin
            wr(OFS_CONFIG, 8'(s));
            `CHK(mem_size_sel, 3'(s))
            `CHK(mem_bank_cnt, s[0] ? 2'h2 : 2'h1)
            `CHK(mem_words_per_bank, 20'h08000 << (2 * s[2:1]))
        end
        $display("test config done");
        wr(OFS_ADDR_HIGH, 8'hFF);
        rd(OFS_ADDR_HIGH);
        `CHK(rv, 8'h1F)
        wr(OFS_ADDR_HIGH, 8'h0A);
        wr(OFS_ADDR_MID, 8'h5C);
        wr(OFS_ADDR_LOW, 8'hA3);
        wr(OFS_DATA, 8'h3E);
        wr(OFS_XFER_CTRL, 8'h01);
        rd(OFS_XFER_CTRL);
        `CHK(rv[7], 1'b0)
        poll();
        `CHK(rv, 8'hC1)
        `CHK(sram.mem[20'hA5CA3], 8'h3E)
        wr(OFS_DATA, 8'h00);
        wr(OFS_XFER_CTRL, 8'h21);
        poll();
        `CHK(rv, 8'hA1)
        rd(OFS_DATA);
        `CHK(rv, 8'h3E)
        // A fresh data byte shows whether a code other than 01 wrongly reads or writes memory.
        wr(OFS_DATA, 8'h77);
        wr(OFS_XFER_CTRL, 8'h22);
        poll();
        rd(OFS_DATA);
        `CHK(rv, 8'h77)
        `CHK(sram.mem[20'hA5CA3], 8'h3E)
        $display("test memory access done");
        test_done();
    end
endmodule : tb_ext_rx_sram_access_regs
`default_nettype wire
